// *** core/edge_capture_cell.sv ***
// One edge line: pulse-catching capture and crossing into the system clock
`timescale 1ns/1ps

module edge_capture_cell (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic line_i,
  input wire logic rise_en_i,
  input wire logic fall_en_i,
  output logic edge_o,
  output logic level_o
);

  logic rise_tog_r;
  logic fall_tog_r;
  edge_event_pkg::capture_state_t s_r;
  edge_event_pkg::capture_state_t s_nxt;

  // Toggle on the line's own rising edge, so pulses shorter than a clock period are kept
  always_ff @(posedge line_i or posedge rst_i)
  begin
    if (rst_i)
      rise_tog_r <= 1'b0;
    else
      rise_tog_r <= ~rise_tog_r;
  end

  // Toggle on the line's own falling edge
  always_ff @(negedge line_i or posedge rst_i)
  begin
    if (rst_i)
      fall_tog_r <= 1'b0;
    else
      fall_tog_r <= ~fall_tog_r;
  end

  // Two-stage crossing of toggles and level; seen copy marks handled edges
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.rise_s1 = rise_tog_r;
    s_nxt.rise_s2 = s_r.rise_s1;
    s_nxt.rise_seen = s_r.rise_s2;
    s_nxt.fall_s1 = fall_tog_r;
    s_nxt.fall_s2 = s_r.fall_s1;
    s_nxt.fall_seen = s_r.fall_s2;
    s_nxt.lvl_s1 = line_i;
    s_nxt.lvl_s2 = s_r.lvl_s1;
    s_nxt.edge_hit = (rise_en_i && (s_r.rise_s2 != s_r.rise_seen)) ||
                     (fall_en_i && (s_r.fall_s2 != s_r.fall_seen));
  end

  // Clock-side registers
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
      s_r <= '0;
    else if (ce_i)
      s_r <= s_nxt;
  end

  assign edge_o = s_r.edge_hit;
  assign level_o = s_r.lvl_s2;

endmodule

// *** core/edge_event_map.svh ***
// Register offsets, reset values and sizes of the edge event controller
`ifndef EDGE_EVENT_MAP_SVH
`define EDGE_EVENT_MAP_SVH

// Line counts and widths
`define EEC_NUM_LINES 19
`define EEC_NUM_PIN_LINES 16
`define EEC_NUM_INT_LINES 3
`define EEC_SEL_W 5
`define EEC_SEL_FIELD_W 8
`define EEC_SEL_PER_REG 4
`define EEC_SEL_REGS 4
`define EEC_ADDR_W 8
`define EEC_DATA_W 32

// Register byte offsets
`define EEC_MASK_OFF 8'h00
`define EEC_EVT_EN_OFF 8'h04
`define EEC_RISE_OFF 8'h08
`define EEC_FALL_OFF 8'h0c
`define EEC_PEND_OFF 8'h10
`define EEC_SWTRIG_OFF 8'h14
`define EEC_SEL_BASE_OFF 8'h18
`define EEC_LEVEL_OFF 8'h28

// Reset values
`define EEC_MASK_RST 19'h00000
`define EEC_EVT_EN_RST 19'h00000
`define EEC_RISE_RST 19'h00000
`define EEC_FALL_RST 19'h00000
`define EEC_PEND_RST 19'h00000
`define EEC_SEL_RST 5'h00

`endif

// *** core/edge_event_pkg.sv ***
// Types shared by the edge event controller modules
`include "edge_event_map.svh"

package edge_event_pkg;

  typedef logic [`EEC_NUM_LINES-1:0] line_vec_t;
  typedef logic [`EEC_NUM_PIN_LINES-1:0][`EEC_SEL_W-1:0] sel_vec_t;

  // Clock-side state of one capture cell
  typedef struct packed {
    logic rise_s1;
    logic rise_s2;
    logic rise_seen;
    logic fall_s1;
    logic fall_s2;
    logic fall_seen;
    logic lvl_s1;
    logic lvl_s2;
    logic edge_hit;
  } capture_state_t;

  // Register file and output state of the controller
  typedef struct packed {
    line_vec_t mask;
    line_vec_t evt_en;
    line_vec_t rise;
    line_vec_t fall;
    line_vec_t pending;
    sel_vec_t sel;
    logic irq;
    line_vec_t evt;
    logic [`EEC_DATA_W-1:0] rdata;
  } ctl_state_t;

endpackage

// *** core/external_edge_event_controller.sv ***
// External edge interrupt and event controller with register port
// How it works
// - Nineteen separate edge lines, each raising an interrupt or an event request.
// - Per line, software picks rising, falling or both edges as trigger.
// - Per line mask stops that line's interrupt request (not its event request) without touching other lines.
// - Per line pending bit records a detected edge until software clears it.
// - Pulses shorter than one clock period are still caught.
// - Sixteen lines are fed from pins; any pin can be routed to each.
//
// Decided for this implementation: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`include "edge_event_map.svh"

module external_edge_event_controller #(
  parameter int NUM_PINS = 25
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [NUM_PINS-1:0] gpio_i,
  input wire logic [`EEC_NUM_INT_LINES-1:0] int_line_i,
  input wire logic [`EEC_ADDR_W-1:0] addr_i,
  input wire logic [`EEC_DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [`EEC_DATA_W-1:0] rdata_o,
  output logic irq_o,
  output logic [`EEC_NUM_LINES-1:0] evt_o
);

  edge_event_pkg::ctl_state_t s_r;
  edge_event_pkg::ctl_state_t s_nxt;
  logic [`EEC_NUM_PIN_LINES-1:0] pin_lines;
  edge_event_pkg::line_vec_t raw_lines;
  edge_event_pkg::line_vec_t edges;
  edge_event_pkg::line_vec_t levels;
  edge_event_pkg::line_vec_t pend_clr;
  edge_event_pkg::line_vec_t pend_set;

  // Widen a line vector into a bus word, upper bits zero
  function automatic logic [`EEC_DATA_W-1:0] line_word(input edge_event_pkg::line_vec_t v);
    logic [`EEC_DATA_W-1:0] w;
    w = '0;
    w[`EEC_NUM_LINES-1:0] = v;
    return w;
  endfunction

  // Pack four line selects of one select register into a word
  function automatic logic [`EEC_DATA_W-1:0] sel_word(input edge_event_pkg::sel_vec_t sel, input int k);
    logic [`EEC_DATA_W-1:0] w;
    w = '0;
    for (int j = 0; j < `EEC_SEL_PER_REG; j++)
    begin
      w[j*`EEC_SEL_FIELD_W +: `EEC_SEL_W] = sel[k*`EEC_SEL_PER_REG+j];
    end
    return w;
  endfunction

  // Byte address of select register k
  function automatic logic [`EEC_ADDR_W-1:0] sel_addr(input int k);
    logic [`EEC_ADDR_W-1:0] a;
    a = `EEC_SEL_BASE_OFF + `EEC_ADDR_W'(k * 4);
    return a;
  endfunction

  // Pin routing for the sixteen pin-fed lines
  line_source_mux #(
    .NUM_PINS(NUM_PINS)
  ) u_mux (
    .pins_i(gpio_i),
    .sel_i(s_r.sel),
    .lines_o(pin_lines)
  );

  // Pin-fed lines low, internal sources on top
  assign raw_lines = {int_line_i, pin_lines};

  // One capture cell per line
  genvar g;
  generate
    for (g = 0; g < `EEC_NUM_LINES; g++)
    begin : g_line
      edge_capture_cell u_cell (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .line_i(raw_lines[g]),
        .rise_en_i(s_r.rise[g]),
        .fall_en_i(s_r.fall[g]),
        .edge_o(edges[g]),
        .level_o(levels[g])
      );
    end
  endgenerate

  // Register writes, pending update, request outputs and read data
  always_comb
  begin
    s_nxt = s_r;
    pend_clr = '0;
    pend_set = '0;
    if (wr_i)
    begin
      if (addr_i == `EEC_MASK_OFF)
        s_nxt.mask = wdata_i[`EEC_NUM_LINES-1:0];
      else if (addr_i == `EEC_EVT_EN_OFF)
        s_nxt.evt_en = wdata_i[`EEC_NUM_LINES-1:0];
      else if (addr_i == `EEC_RISE_OFF)
        s_nxt.rise = wdata_i[`EEC_NUM_LINES-1:0];
      else if (addr_i == `EEC_FALL_OFF)
        s_nxt.fall = wdata_i[`EEC_NUM_LINES-1:0];
      else if (addr_i == `EEC_PEND_OFF)
        pend_clr = wdata_i[`EEC_NUM_LINES-1:0];
      else if (addr_i == `EEC_SWTRIG_OFF)
        pend_set = wdata_i[`EEC_NUM_LINES-1:0];
      else
      begin
        for (int k = 0; k < `EEC_SEL_REGS; k++)
        begin
          if (addr_i == sel_addr(k))
          begin
            for (int j = 0; j < `EEC_SEL_PER_REG; j++)
            begin
              s_nxt.sel[k*`EEC_SEL_PER_REG+j] = wdata_i[j*`EEC_SEL_FIELD_W +: `EEC_SEL_W];
            end
          end
        end
      end
    end
    // A detected edge wins over a clear in the same cycle
    s_nxt.pending = (s_r.pending & ~pend_clr) | edges | pend_set;
    // Interrupt only from unmasked pending lines
    s_nxt.irq = |(s_nxt.pending & s_nxt.mask);
    // Event pulse for each enabled line with a fresh edge
    s_nxt.evt = edges & s_r.evt_en;
    // Read data only in the cycle after a read
    s_nxt.rdata = '0;
    if (rd_i)
    begin
      if (addr_i == `EEC_MASK_OFF)
        s_nxt.rdata = line_word(s_r.mask);
      else if (addr_i == `EEC_EVT_EN_OFF)
        s_nxt.rdata = line_word(s_r.evt_en);
      else if (addr_i == `EEC_RISE_OFF)
        s_nxt.rdata = line_word(s_r.rise);
      else if (addr_i == `EEC_FALL_OFF)
        s_nxt.rdata = line_word(s_r.fall);
      else if (addr_i == `EEC_PEND_OFF)
        s_nxt.rdata = line_word(s_r.pending);
      else if (addr_i == `EEC_LEVEL_OFF)
        s_nxt.rdata = line_word(levels);
      else
      begin
        for (int k = 0; k < `EEC_SEL_REGS; k++)
        begin
          if (addr_i == sel_addr(k))
            s_nxt.rdata = sel_word(s_r.sel, k);
        end
      end
    end
  end

  // State register with clock enable
  always_ff @(posedge sys_clk_i)
  begin
    if (rst_i)
    begin
      s_r.mask <= `EEC_MASK_RST;
      s_r.evt_en <= `EEC_EVT_EN_RST;
      s_r.rise <= `EEC_RISE_RST;
      s_r.fall <= `EEC_FALL_RST;
      s_r.pending <= `EEC_PEND_RST;
      s_r.sel <= {`EEC_NUM_PIN_LINES{`EEC_SEL_RST}};
      s_r.irq <= 1'b0;
      s_r.evt <= '0;
      s_r.rdata <= '0;
    end
    else if (ce_i)
      s_r <= s_nxt;
  end

  // Outputs straight from flops
  assign rdata_o = s_r.rdata;
  assign irq_o = s_r.irq;
  assign evt_o = s_r.evt;

endmodule

// *** core/line_source_mux.sv ***
// Routes any pin to each of the pin-fed edge lines
`timescale 1ns/1ps
`include "edge_event_map.svh"

module line_source_mux #(
  parameter int NUM_PINS = 25
) (
  input wire logic [NUM_PINS-1:0] pins_i,
  input wire edge_event_pkg::sel_vec_t sel_i,
  output logic [`EEC_NUM_PIN_LINES-1:0] lines_o
);

  // Per-line pin pick; out-of-range picks read low
  always_comb
  begin
    for (int i = 0; i < `EEC_NUM_PIN_LINES; i++)
    begin
      if (int'(sel_i[i]) < NUM_PINS)
        lines_o[i] = pins_i[sel_i[i]];
      else
        lines_o[i] = 1'b0;
    end
  end

endmodule

// *** tb/edge_partner.sv ***
// Pin and internal source model feeding the edge lines
`timescale 1ns/1ps
module edge_partner (
  output logic [24:0] gpio_o,
  output logic [2:0] int_o
);
  // All sources start low
  initial
  begin
    gpio_o = 25'h0;
    int_o = 3'h0;
  end
  // Indices past the pins reach internal lines
  task automatic drive(input int n, input logic v);
    if (n < 25)
      gpio_o[n] = v;
    else
      int_o[n-25] = v;
  endtask
endmodule

// *** tb/eec_asserts.sv ***
// Port assertions for the edge event controller
`timescale 1ns/1ps
`include "edge_event_map.svh"
module eec_asserts #(
  parameter int NUM_PINS = 25
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [31:0] rdata_o,
  input wire logic irq_o,
  input wire logic [18:0] evt_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // Writes that close a gate
  sequence mask_off_s;
    wr_i && addr_i == `EEC_MASK_OFF && wdata_i[18:0] == 19'h0;
  endsequence
  sequence evt_off_s;
    wr_i && addr_i == `EEC_EVT_EN_OFF && wdata_i[18:0] == 19'h0;
  endsequence
  rst_quiet_a: assert property ($past(rst_i) |-> rdata_o == 32'h0 && !irq_o && evt_o == 19'h0)
    else $error("outputs busy after reset");
  rdata_idle_a: assert property (!$past(rd_i) |-> rdata_o == 32'h0)
    else $error("stray read data");
  resv_bits_a: assert property (rd_i && addr_i <= 8'h14 |=> rdata_o[31:19] == 13'h0)
    else $error("reserved bits set");
  sel_resv_a: assert property (rd_i && addr_i >= 8'h18 && addr_i < 8'h28 |=> (rdata_o & 32'he0e0e0e0) == 32'h0)
    else $error("select spare bits set");
  unmapped_rd_a: assert property (rd_i && addr_i > `EEC_LEVEL_OFF |=> rdata_o == 32'h0)
    else $error("unmapped read not zero");
  irq_fall_a: assert property ($fell(irq_o) |-> $past(wr_i) || $past(wr_i, 2))
    else $error("irq dropped unasked");
  mask_off_a: assert property (mask_off_s |=> !irq_o)
    else $error("irq despite mask");
  evt_off_a: assert property (evt_off_s |-> ##2 evt_o == 19'h0)
    else $error("event despite disable");
endmodule
bind external_edge_event_controller eec_asserts #(.NUM_PINS(NUM_PINS)) chk_u (
  .sys_clk_i(sys_clk_i),
  .rst_i(rst_i),
  .addr_i(addr_i),
  .wdata_i(wdata_i),
  .wr_i(wr_i),
  .rd_i(rd_i),
  .rdata_o(rdata_o),
  .irq_o(irq_o),
  .evt_o(evt_o)
);

// *** tb/tb.sv ***
// Self-checking bench for the edge event controller
`timescale 1ns/1ps
`include "edge_event_map.svh"
module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ce = 1'b1;
  logic [31:0] rdata;
  logic irq;
  logic [18:0] evt;
  logic [18:0] evt_acc = 19'h0;
  logic [24:0] gpio;
  logic [2:0] intl;
  int n_errors = 0;
  int total_checks = 0;
  // 250 MHz clock
  initial
  begin
    forever #2 clk = ~clk;
  end
  edge_partner peer (.gpio_o(gpio), .int_o(intl));
  external_edge_event_controller dut (.sys_clk_i(clk), .rst_i(rst), .ce_i(ce), .gpio_i(gpio),
    .int_line_i(intl), .addr_i(addr), .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .irq_o(irq), .evt_o(evt));
  // Collect event pulses
  always @(posedge clk)
    if (!rst)
      evt_acc <= evt_acc | evt;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk(rdata, e);
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    idle(8);
    @(posedge clk) rst <= 1'b0;
    idle(4);
    for (int a = 0; a <= 40; a += 4)
      rd_reg(8'(a), 32'h0);
    wr_reg(`EEC_MASK_OFF, 32'h10001);
    wr_reg(`EEC_EVT_EN_OFF, 32'h7);
    wr_reg(`EEC_RISE_OFF, 32'h10005);
    wr_reg(`EEC_FALL_OFF, 32'h6);
    wr_reg(`EEC_SEL_BASE_OFF, 32'h17161514);
    idle(4);
    for (int i = 20; i < 24; i++)
      peer.drive(i, 1'b1);
    idle(8);
    rd_reg(`EEC_PEND_OFF, 32'h5);
    chk({31'h0, irq}, 32'h1);
    rd_reg(`EEC_LEVEL_OFF, 32'hf);
    wr_reg(`EEC_PEND_OFF, 32'h0);
    rd_reg(`EEC_PEND_OFF, 32'h5);
    wr_reg(`EEC_PEND_OFF, 32'h5);
    rd_reg(`EEC_PEND_OFF, 32'h0);
    chk({31'h0, irq}, 32'h0);
    for (int i = 20; i < 24; i++)
      peer.drive(i, 1'b0);
    idle(8);
    rd_reg(`EEC_PEND_OFF, 32'h6);
    chk({31'h0, irq}, 32'h0);
    chk({13'h0, evt_acc}, 32'h7);
    // Pulse narrower than a clock period
    peer.drive(25, 1'b1);
    #1 peer.drive(25, 1'b0);
    idle(8);
    rd_reg(`EEC_PEND_OFF, 32'h10006);
    chk({13'h0, evt_acc}, 32'h7);
    chk({31'h0, irq}, 32'h1);
    wr_reg(`EEC_PEND_OFF, 32'h10006);
    wr_reg(`EEC_SWTRIG_OFF, 32'h40000);
    rd_reg(`EEC_PEND_OFF, 32'h40000);
    chk({31'h0, irq}, 32'h0);
    wr_reg(`EEC_MASK_OFF, 32'h40000);
    idle(2);
    chk({31'h0, irq}, 32'h1);
    wr_reg(`EEC_MASK_OFF, 32'h0);
    wr_reg(`EEC_EVT_EN_OFF, 32'h0);
    rd_reg(`EEC_SEL_BASE_OFF, 32'h17161514);
    chk({31'h0, irq}, 32'h0);
    // Frozen block ignores a write
    @(posedge clk) ce <= 1'b0;
    wr_reg(`EEC_MASK_OFF, 32'h7ffff);
    @(posedge clk) ce <= 1'b1;
    rd_reg(`EEC_MASK_OFF, 32'h0);
    chk({31'h0, irq}, 32'h0);
    rd_reg(8'h40, 32'h0);
    end_of_test;
  end
  // Watchdog
  initial
  begin
    #20000;
    n_errors++;
    end_of_test;
  end
endmodule
